// File: src/sdram_cfg_pkg.sv
// Constants, field layout and types of the SDRAM timing and buffer configuration block
// Notes on behaviour
// - Activate waits the programmed precharge-to-activate clocks, 1 to 15, after precharge.
// - Precharge waits the programmed activate-to-precharge clocks, 1 to 15, after activate.
// - Read or write waits the programmed activate-to-command clocks, never below two.
// - Buffer type from bits 22 and 20: 01 registered, 10 in-line, others reserved.
// - In-line mode enables processor-side parity and SDRAM-side ECC or parity.
// - Ten-bit burst counter reloads on each read or write; expiry issues precharge.
// - Bit 15 set selects registered modules; cleared selects unbuffered modules.
// - With registered modules write data is driven one cycle after the command.
// - Power-up configuration writes the mode-word field into the SDRAM mode register.
// - CAS latency codes 001, 010, 011 mean one, two, three clocks; others reserved.
// - The fourteen-bit mode word has seven zero bits above the programmed field.
// - In 32-bit path, bit 23 clear means four-beat ROM; bursts split in two.
// - Bit 21 set enables the extended 128 Mbyte ROM space; clear disables it.
package sdram_cfg_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CFG4   = 12'h0fc;
  localparam logic [11:0] ADDR_CTRL   = 12'h100;
  localparam logic [11:0] ADDR_STATUS = 12'h104;

  localparam logic [31:0] CFG4_RESET  = 32'h0010_0000;
  localparam logic [31:0] CFG4_WMASK  = 32'hfffe_ffff;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PRE_TO_ACT_LSB  = 28;
  localparam int ACT_TO_PRE_LSB  = 24;
  localparam int ROM_BURST_BIT   = 23;
  localparam int BUF_HI_BIT      = 22;
  localparam int EXT_ROM_BIT     = 21;
  localparam int BUF_LO_BIT      = 20;
  localparam int BST_HI_LSB      = 18;
  localparam int REG_MODULE_BIT  = 15;
  localparam int MODE_LSB        = 8;
  localparam int CAS_LSB         = 12;
  localparam int WRAP_BIT        = 11;
  localparam int BLEN_LSB        = 8;
  localparam int ACT_TO_RW_LSB   = 4;
  localparam int BST_LO_LSB      = 0;
  localparam int CTRL_BST_LSB    = 0;
  localparam int CTRL_INIT_BIT   = 8;
  localparam int CTRL_DP32_BIT   = 9;

  // ---------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_BST_RESET  = 4'h0;
  localparam logic [3:0] ACT_TO_RW_MIN   = 4'h2;
  localparam logic [1:0] BUF_REGISTERED  = 2'h1;
  localparam logic [1:0] BUF_INLINE      = 2'h2;
  localparam logic [4:0] MODE_OPCODE     = 5'h00;
  localparam logic [1:0] MODE_PAD        = 2'h0;
  localparam logic [2:0] BLEN_FOUR       = 3'h2;
  localparam logic       WRAP_SEQ        = 1'b0;
  localparam logic [7:0] GAP_MAX         = 8'hff;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD  = 3'h2,
    CMD_WR  = 3'h3,
    CMD_PRE = 3'h4,
    CMD_MRS = 3'h5
  } sd_cmd_t;

  typedef enum logic [1:0] {
    OP_ACT = 2'h0,
    OP_RD  = 2'h1,
    OP_WR  = 2'h2,
    OP_PRE = 2'h3
  } req_op_t;

  typedef enum logic [1:0] {
    ST_RESET  = 2'h0,
    ST_MODE   = 2'h1,
    ST_CLOSED = 2'h3,
    ST_OPEN   = 2'h2
  } ctl_state_t;

endpackage

// File: src/sdram_timing_buffer_config.sv
// SDRAM timing enforcement and buffer configuration with an APB register port
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module sdram_timing_buffer_config
  import sdram_cfg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_op,
  output      logic        req_ack,
  output      logic [2:0]  sd_cmd,
  output      logic [13:0] sd_addr,
  output      logic        wdata_oe,
  output      logic [1:0]  cas_latency_clocks,
  output      logic        registered_module_select,
  output      logic        inline_ecc_enable,
  output      logic        cpu_parity_enable,
  output      logic        rom_two_transactions,
  output      logic        extended_rom_enable
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cfg4;
    logic [3:0]  bst_mid;
    logic        dp32;
    logic        init_req;
    ctl_state_t  state;
    logic [3:0]  pre_cnt;
    logic [3:0]  act_pre_cnt;
    logic [3:0]  act_rw_cnt;
    logic [9:0]  burst_cnt;
    logic        burst_run;
    sd_cmd_t     cmd;
    logic [13:0] addr;
    logic        wdata_oe;
    logic        wdata_late;
    logic        ack;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  cas;
    logic        regmod;
    logic        ecc_en;
    logic        par_en;
    logic        rom_split;
    logic        ext_rom;
    logic        mode_bad;
    logic [7:0]  since_pre;
    logic [7:0]  since_act;
  } ctl_t;

  ctl_t s_ff;
  ctl_t nxt_s;

  // ---------------------------------------------------------------
  // Decoders
  // ---------------------------------------------------------------
  // Zero is not a legal interval code; it is treated as one clock
  function automatic logic [3:0] clocks_of(input logic [3:0] code);
    clocks_of = (code == 4'h0) ? 4'h1 : code;
  endfunction

  function automatic logic [3:0] rw_clocks(input logic [3:0] code);
    rw_clocks = (code < ACT_TO_RW_MIN) ? ACT_TO_RW_MIN : code;
  endfunction

  function automatic logic [1:0] cas_clocks(input logic [2:0] code);
    case (code)
      3'h1:    cas_clocks = 2'h1;
      3'h2:    cas_clocks = 2'h2;
      3'h3:    cas_clocks = 2'h3;
      default: cas_clocks = 2'h0;
    endcase
  endfunction

  // 0 unmapped, 1 config, 2 control, 3 status
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    case (a)
      ADDR_CFG4:   reg_sel = 2'h1;
      ADDR_CTRL:   reg_sel = 2'h2;
      ADDR_STATUS: reg_sel = 2'h3;
      default:     reg_sel = 2'h0;
    endcase
  endfunction

  logic [3:0] f_pre_act;
  logic [3:0] f_act_pre;
  logic [3:0] f_act_rw;
  logic [1:0] f_buf;
  logic [9:0] f_burst;
  logic [6:0] f_mode;

  assign f_pre_act = s_ff.cfg4[PRE_TO_ACT_LSB +: 4];
  assign f_act_pre = s_ff.cfg4[ACT_TO_PRE_LSB +: 4];
  assign f_act_rw  = s_ff.cfg4[ACT_TO_RW_LSB +: 4];
  assign f_buf     = {s_ff.cfg4[BUF_HI_BIT], s_ff.cfg4[BUF_LO_BIT]};
  assign f_burst   = {s_ff.cfg4[BST_HI_LSB +: 2], s_ff.bst_mid, s_ff.cfg4[BST_LO_LSB +: 4]};
  assign f_mode    = s_ff.cfg4[MODE_LSB +: 7];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic setup;
    logic access;
    logic take;
    logic [1:0] sel;
    logic init_set;
    setup  = psel && !penable;
    access = psel && penable && s_ff.pready;
    take   = req_valid && !s_ff.ack;
    sel    = reg_sel(paddr);
    init_set = access && pwrite && (sel == 2'h2) && pwdata[CTRL_INIT_BIT];
    nxt_s  = s_ff;

    nxt_s.ack        = 1'b0;
    nxt_s.cmd        = CMD_NOP;
    nxt_s.wdata_oe   = s_ff.wdata_late;
    nxt_s.wdata_late = 1'b0;
    if (s_ff.pre_cnt != 4'h0)
      nxt_s.pre_cnt = s_ff.pre_cnt - 4'h1;
    if (s_ff.act_pre_cnt != 4'h0)
      nxt_s.act_pre_cnt = s_ff.act_pre_cnt - 4'h1;
    if (s_ff.act_rw_cnt != 4'h0)
      nxt_s.act_rw_cnt = s_ff.act_rw_cnt - 4'h1;
    if (s_ff.burst_cnt != 10'h000)
      nxt_s.burst_cnt = s_ff.burst_cnt - 10'h001;

    // APB: one setup cycle, then an access cycle with pready high
    nxt_s.pready = setup;
    if (setup)
    begin
      nxt_s.pslverr = (sel == 2'h0);
      case (sel)
        2'h1:    nxt_s.prdata = s_ff.cfg4;
        2'h2:    nxt_s.prdata = {22'h0, s_ff.dp32, s_ff.init_req, 4'h0, s_ff.bst_mid};
        2'h3:    nxt_s.prdata = {s_ff.burst_cnt, 18'h0, s_ff.state,
                                 s_ff.mode_bad, s_ff.burst_run};
        default: nxt_s.prdata = 32'h0;
      endcase
    end
    if (access && pwrite)
    begin
      if (sel == 2'h1)
        nxt_s.cfg4 = pwdata & CFG4_WMASK;
      if (sel == 2'h2)
      begin
        nxt_s.bst_mid = pwdata[CTRL_BST_LSB +: 4];
        nxt_s.dp32    = pwdata[CTRL_DP32_BIT];
        if (pwdata[CTRL_INIT_BIT])
          nxt_s.init_req = 1'b1;
      end
    end

    case (s_ff.state)
      ST_RESET:
        if (s_ff.init_req)
          nxt_s.state = ST_MODE;
      ST_MODE:
      begin
        nxt_s.cmd      = CMD_MRS;
        nxt_s.addr     = {MODE_PAD, MODE_OPCODE, f_mode};
        // A start written in this very cycle wins over the clear and stays pending
        if (!init_set)
          nxt_s.init_req = 1'b0;
        nxt_s.state    = ST_CLOSED;
      end
      ST_CLOSED:
        if (take)
        begin
          if (req_op_t'(req_op) != OP_ACT)
            nxt_s.ack = 1'b1;
          else if (s_ff.pre_cnt == 4'h0)
          begin
            nxt_s.cmd         = CMD_ACT;
            nxt_s.ack         = 1'b1;
            nxt_s.act_pre_cnt = clocks_of(f_act_pre) - 4'h1;
            nxt_s.act_rw_cnt  = rw_clocks(f_act_rw) - 4'h1;
            nxt_s.state       = ST_OPEN;
          end
        end
      ST_OPEN:
        // Expiry wins over a waiting request once the activate-to-precharge interval has also run out
        if (s_ff.burst_run && s_ff.burst_cnt == 10'h000 && s_ff.act_pre_cnt == 4'h0)
          nxt_s.cmd = CMD_PRE;
        else if (take)
        begin
          case (req_op_t'(req_op))
            OP_PRE:
              if (s_ff.act_pre_cnt == 4'h0)
              begin
                nxt_s.cmd = CMD_PRE;
                nxt_s.ack = 1'b1;
              end
            OP_RD, OP_WR:
              if (s_ff.act_rw_cnt == 4'h0)
              begin
                nxt_s.cmd       = (req_op_t'(req_op) == OP_WR) ? CMD_WR : CMD_RD;
                nxt_s.ack       = 1'b1;
                nxt_s.burst_cnt = f_burst;
                nxt_s.burst_run = 1'b1;
                if (req_op_t'(req_op) == OP_WR)
                begin
                  // Registered modules latch the command one cycle before the data
                  nxt_s.wdata_late = s_ff.regmod;
                  nxt_s.wdata_oe   = !s_ff.regmod;
                end
              end
            default:
              nxt_s.ack = 1'b1;
          endcase
        end
      default:
        nxt_s.state = ST_RESET;
    endcase

    if (nxt_s.cmd == CMD_PRE)
    begin
      nxt_s.pre_cnt   = clocks_of(f_pre_act) - 4'h1;
      nxt_s.burst_run = 1'b0;
      nxt_s.state     = ST_CLOSED;
    end

    nxt_s.since_pre = (nxt_s.cmd == CMD_PRE) ? 8'h00 :
                      (s_ff.since_pre == GAP_MAX) ? GAP_MAX : s_ff.since_pre + 8'h01;
    nxt_s.since_act = (nxt_s.cmd == CMD_ACT) ? 8'h00 :
                      (s_ff.since_act == GAP_MAX) ? GAP_MAX : s_ff.since_act + 8'h01;

    nxt_s.cas       = cas_clocks(s_ff.cfg4[CAS_LSB +: 3]);
    nxt_s.mode_bad  = (nxt_s.cas == 2'h0) || (s_ff.cfg4[WRAP_BIT] != WRAP_SEQ) ||
                      (s_ff.cfg4[BLEN_LSB +: 3] != BLEN_FOUR);
    nxt_s.regmod    = s_ff.cfg4[REG_MODULE_BIT];
    nxt_s.ecc_en    = (f_buf == BUF_INLINE);
    nxt_s.par_en    = (f_buf == BUF_INLINE);
    nxt_s.rom_split = s_ff.dp32 && !s_ff.cfg4[ROM_BURST_BIT];
    nxt_s.ext_rom   = s_ff.cfg4[EXT_ROM_BIT];
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff           <= '0;
      s_ff.cfg4      <= CFG4_RESET;
      s_ff.bst_mid   <= CTRL_BST_RESET;
      s_ff.state     <= ST_RESET;
      s_ff.cmd       <= CMD_NOP;
      s_ff.since_pre <= GAP_MAX;
      s_ff.since_act <= GAP_MAX;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign prdata                   = s_ff.prdata;
  assign pready                   = s_ff.pready;
  assign pslverr                  = s_ff.pslverr;
  assign req_ack                  = s_ff.ack;
  assign sd_cmd                   = s_ff.cmd;
  assign sd_addr                  = s_ff.addr;
  assign wdata_oe                 = s_ff.wdata_oe;
  assign cas_latency_clocks       = s_ff.cas;
  assign registered_module_select = s_ff.regmod;
  assign inline_ecc_enable        = s_ff.ecc_en;
  assign cpu_parity_enable        = s_ff.par_en;
  assign rom_two_transactions     = s_ff.rom_split;
  assign extended_rom_enable      = s_ff.ext_rom;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_pre_act_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (sd_cmd == CMD_ACT) |-> (s_ff.since_pre >= {4'h0, clocks_of(f_pre_act)}))
    else $error("activate issued too soon after precharge");

  chk_act_pre_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (sd_cmd == CMD_PRE) |-> (s_ff.since_act >= {4'h0, clocks_of(f_act_pre)}))
    else $error("precharge issued too soon after activate");

  chk_act_rw_gap: assert property (@(posedge pclk) disable iff (!presetn)
    (sd_cmd == CMD_RD || sd_cmd == CMD_WR) |-> (s_ff.since_act >= {4'h0, rw_clocks(f_act_rw)}))
    else $error("read or write issued too soon after activate");

  chk_buf_inline: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (inline_ecc_enable && cpu_parity_enable) == ($past(f_buf) == BUF_INLINE))
    else $error("in-line checking does not follow buffer type");

  chk_burst_expiry: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ff.state == ST_OPEN && s_ff.burst_run && s_ff.burst_cnt == 10'h000
     && s_ff.act_pre_cnt == 4'h0) |=> (sd_cmd == CMD_PRE))
    else $error("expired burst counter did not close the page");

  chk_wdata_normal: assert property (@(posedge pclk) disable iff (!presetn)
    (sd_cmd == CMD_WR && !$past(registered_module_select)) |-> wdata_oe ##1 !wdata_oe)
    else $error("unbuffered write data not aligned with command");

  chk_wdata_late: assert property (@(posedge pclk) disable iff (!presetn)
    (sd_cmd == CMD_WR && $past(registered_module_select)) |-> !wdata_oe ##1 wdata_oe)
    else $error("registered write data not one cycle late");

  chk_mode_word: assert property (@(posedge pclk) disable iff (!presetn)
    (sd_cmd == CMD_MRS) |-> (sd_addr == {MODE_PAD, MODE_OPCODE, $past(f_mode)}))
    else $error("mode word not formed from the programmed field");

  chk_cas_decode: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (cas_latency_clocks == (($past(s_ff.cfg4[CAS_LSB +: 3]) inside {3'h1, 3'h2, 3'h3})
         ? $past(s_ff.cfg4[CAS_LSB +: 2]) : 2'h0)))
    else $error("CAS latency decode wrong");

  chk_rom_split: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (rom_two_transactions == ($past(s_ff.dp32) && !$past(s_ff.cfg4[ROM_BURST_BIT]))))
    else $error("ROM burst split wrong");

  chk_ext_rom: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (extended_rom_enable == $past(s_ff.cfg4[EXT_ROM_BIT])))
    else $error("extended ROM enable does not follow its bit");

  chk_mode_issue: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ff.state == ST_MODE) |=> (sd_cmd == CMD_MRS))
    else $error("mode register set not issued during init");

  chk_reg_module: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (registered_module_select == $past(s_ff.cfg4[REG_MODULE_BIT])))
    else $error("registered module select does not follow its bit");

  chk_buf_type: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (inline_ecc_enable ==
         ($past(s_ff.cfg4[BUF_HI_BIT]) && !$past(s_ff.cfg4[BUF_LO_BIT]))))
    else $error("in-line mode does not follow the buffer type bits");

endmodule

// File: tb/sdram_device_model.sv
// Behavioural SDRAM device that latches every mode register write
`timescale 1ns/1ps
module sdram_device_model
  import sdram_cfg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [2:0]  sd_cmd,
  input  wire logic [13:0] sd_addr,
  output      logic [13:0] mode_reg,
  output      int          mode_sets
);
  // A real device keeps its mode register; clearing it here exposes a missing write
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mode_reg  <= 14'h0000;
      mode_sets <= 0;
    end
    else if (sd_cmd == CMD_MRS)
    begin
      mode_reg  <= sd_addr;
      mode_sets <= mode_sets + 1;
    end
endmodule

// File: tb/tb_sdram_timing_buffer_config.sv
// Self-checking bench for the SDRAM timing and buffer configuration block
`timescale 1ns/1ps
module tb_sdram_timing_buffer_config;
  import sdram_cfg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, rd;
  logic        req_valid, req_ack, wdata_oe, reg_sel, inl_ecc, cpu_par, rom_two, ext_rom;
  logic [1:0]  req_op, cas;
  logic [2:0]  sd_cmd;
  logic [13:0] sd_addr, mode_reg;
  logic        er, reg_mod;
  int          mode_sets, err_total, checked, seed, s, t, t_act, t_pre, i, n, pe, ae, re;
  int          cyc = 0;

  sdram_timing_buffer_config DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_op(req_op), .req_ack(req_ack), .sd_cmd(sd_cmd),
    .sd_addr(sd_addr), .wdata_oe(wdata_oe), .cas_latency_clocks(cas),
    .registered_module_select(reg_sel), .inline_ecc_enable(inl_ecc),
    .cpu_parity_enable(cpu_par), .rom_two_transactions(rom_two),
    .extended_rom_enable(ext_rom));

  sdram_device_model mem (
    .pclk(pclk), .presetn(presetn), .sd_cmd(sd_cmd), .sd_addr(sd_addr),
    .mode_reg(mode_reg), .mode_sets(mode_sets));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // Compare, bus and request tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_time(input string nm, input int e, input int g);
    checked++;
    if (g != e)
    begin
      err_total++;
      $display("unexpected %s cycle: expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic timeout;
    err_total++;
    $display("unexpected handshake: expected answer seen none");
    test_done();
  endtask
  // Starts one edge late so a request never follows a release in the same step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (n == 20)
      timeout();
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Gap of -1 means the request is refused and its timing is not judged
  task automatic issue(input req_op_t op, input logic [2:0] c, input int g, input int gap,
                       input string nm);
    @(posedge pclk);
    s = cyc;
    req_valid <= 1'b1;
    req_op    <= op;
    for (n = 0; n < 40 && req_ack !== 1'b1; n++)
      @(posedge pclk);
    if (n == 40)
      timeout();
    t = cyc;
    req_valid <= 1'b0;
    cmp_val(nm, 32'(c), 32'(sd_cmd));
    if (gap >= 0)
      cmp_time(nm, (s + 2 > g + gap) ? s + 2 : g + gap, t);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 32'hfdb595fc;
    {psel, penable, pwrite, paddr, pwdata, req_valid, req_op} = '0;
    err_total = 0;
    checked   = 0;
    presetn   = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CFG4, 32'h0);
    cmp_val("cfg4 reset", CFG4_RESET, rd);
    apb(1'b1, ADDR_CFG4, 32'hffff_ffff);
    apb(1'b0, ADDR_CFG4, 32'h0);
    cmp_val("cfg4 readback", CFG4_WMASK, rd);
    apb(1'b0, 12'h200, 32'h0);
    cmp_val("unmapped error", 32'h1, 32'(er));
    cmp_val("unmapped data", 32'h0, rd);
    $display("test registers done");
    for (i = 0; i < 8; i++)
    begin
      // Bits 23 to 20: rom burst, buffer high, extended rom, buffer low
      v = {8'h00, 4'(i[0] * 8 + i[1] * 4 + i[2] * 2 + i[0]), 4'h0, 1'(i[1] ^ i[0]),
           3'(i), 12'h200};
      apb(1'b1, ADDR_CTRL, 32'(i[2]) << CTRL_DP32_BIT);
      apb(1'b1, ADDR_CFG4, v);
      repeat (3) @(posedge pclk);
      cmp_val("cas clocks", (i >= 1 && i <= 3) ? 32'(i) : 32'h0, 32'(cas));
      cmp_val("inline ecc", 32'(i[1] & ~i[0]), 32'(inl_ecc));
      cmp_val("cpu parity", 32'(i[1] & ~i[0]), 32'(cpu_par));
      cmp_val("registered", 32'(i[1] ^ i[0]), 32'(reg_sel));
      cmp_val("ext rom", 32'(i[2]), 32'(ext_rom));
      cmp_val("rom split", 32'(i[2] & ~i[0]), 32'(rom_two));
    end
    $display("test decode done");
    apb(1'b1, ADDR_CFG4, 32'h2240_2223);
    apb(1'b1, ADDR_CTRL, 32'h0000_030f);
    for (n = 0; n < 20 && mode_sets == 0; n++)
      @(posedge pclk);
    if (n == 20)
      timeout();
    cmp_val("mode word", 32'h0000_0022, 32'(mode_reg));
    $display("test init done");
    t_pre = -100;
    for (i = 0; i < 6; i++)
    begin
      pe = $unsigned($random(seed)) % 7;
      ae = $unsigned($random(seed)) % 7;
      re = $unsigned($random(seed)) % 7;
      reg_mod = 1'($random(seed));
      apb(1'b1, ADDR_CFG4, {4'(pe), 4'(ae), 8'h4c, reg_mod, 7'h22, 4'(re), 4'hf});
      pe = (pe == 0) ? 1 : pe;
      ae = (ae == 0) ? 1 : ae;
      re = (re < 2) ? 2 : re;
      repeat (16) @(posedge pclk);
      issue(OP_ACT, CMD_ACT, t_pre, pe, "activate");
      t_act = t;
      issue(i[0] ? OP_WR : OP_RD, i[0] ? CMD_WR : CMD_RD, t_act, re, "access");
      if (i[0])
      begin
        cmp_val("write drive", 32'(!reg_mod), 32'(wdata_oe));
        @(posedge pclk);
        cmp_val("late write drive", 32'(reg_mod), 32'(wdata_oe));
      end
      issue(OP_ACT, CMD_NOP, 0, -1, "open activate");
      issue(OP_PRE, CMD_PRE, t_act, ae, "precharge");
      issue(OP_ACT, CMD_ACT, t, pe, "reactivate");
      issue(OP_PRE, CMD_PRE, t, ae, "close");
      t_pre = t;
      issue(OP_RD, CMD_NOP, 0, -1, "closed read");
    end
    $display("test timing done");
    apb(1'b1, ADDR_CTRL, 32'h0000_0201);
    // Burst count {01, 0001, 0011} uses all three parts of the counter
    apb(1'b1, ADDR_CFG4, 32'h1145_2223);
    repeat (16) @(posedge pclk);
    issue(OP_ACT, CMD_ACT, t_pre, 1, "activate");
    issue(OP_RD, CMD_RD, t, 2, "read");
    for (n = 0; n < 400 && sd_cmd !== CMD_PRE; n++)
      @(posedge pclk);
    if (n == 400)
      timeout();
    cmp_time("burst expiry", t + 275 + 1, cyc);
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp_val("status", 32'h0000_000c, rd);
    apb(1'b0, ADDR_CTRL, 32'h0);
    cmp_val("control", 32'h0000_0201, rd);
    $display("test burst done");
    test_done();
  end
endmodule
